// ===== hdl/cct_pkg.sv
// shared constants and types of the core cycle timing control block
// Overview of operation
// - At normal speed each machine cycle lasts exactly one clock, not twelve.
// - An instruction normally spends one machine cycle per fetched byte plus one cycle to execute; a three-byte one has no execute cycle.
// - An external data move takes as few as two machine cycles, a direct-to-direct move three.
// - Only the cycle count differs from the original core; results, pointers and flags match.
// - Software may add a stretch of up to 10 machine cycles to each external data access.
// - External memory modes needing several clocks per cycle lengthen those cycles.
// - Power-management mode stretches every machine cycle to 1024 clocks.
// - With switchback enabled a pending interrupt ends power-management mode by itself.
// - When so configured, the address latch strobe stays low outside external accesses.
// - Timers are stopped after reset; once started they count once per 12 clocks, and each may be set to count every clock.
// - A low program-memory source pin sends every code fetch to external memory.
// - External data writes drive the active-low write strobe on port 3 bit 6.
// - External data reads drive the active-low read strobe on port 3 bit 7.
// - Two data pointers exist, with optional auto increment or decrement and auto toggle.
package cct_pkg;
   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DPTR0 = 8'h04;
   localparam logic [7:0] ADDR_DPTR1 = 8'h08;
   localparam logic [7:0] ADDR_INSTR = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_TMR0 = 8'h14;
   localparam logic [7:0] ADDR_TMR1 = 8'h18;
   localparam logic [7:0] ADDR_TMR2 = 8'h1c;
   localparam logic [31:0] CTRL_RESET = 32'h0;
   // ****************************************************************
   // timing counts
   // ****************************************************************
   localparam int DIV_W = 11;
   localparam logic [10:0] DIV_NORMAL = 11'h001;
   localparam logic [10:0] DIV_PMM = 11'h400;
   localparam logic [10:0] DIV_TMR_LEGACY = 11'h00c;
   localparam logic [3:0] STRETCH_MAX = 4'ha;
   localparam int NUM_TMR = 3;
   // ****************************************************************
   // field layouts
   // ****************************************************************
   typedef struct packed {
      logic [10:0] rsv_hi;
      logic [2:0] tmr_run;
      logic [1:0] ext_mode;
      logic dp_sel;
      logic dp_toggle;
      logic dp_dec;
      logic dp_auto;
      logic rsv_mid;
      logic [2:0] tmr_fast;
      logic [3:0] stretch;
      logic rsv_lo;
      logic ale_quiet;
      logic swb_en;
      logic pmm;
   } cct_ctrl_t;
   typedef enum logic [1:0] {
      KIND_PLAIN = 2'h0,
      KIND_XREAD = 2'h1,
      KIND_XWRITE = 2'h2,
      KIND_RSV = 2'h3
   } cct_kind_t;
   typedef struct packed {
      logic [15:0] rsv_hi;
      logic [7:0] wdata;
      logic [3:0] rsv_lo;
      cct_kind_t kind;
      logic [1:0] nbytes;
   } cct_instr_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_FETCH = 4'h2,
      ST_EXEC = 4'h4,
      ST_XACC = 4'h8
   } cct_state_t;
endpackage

// ===== hdl/cct_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module cct_sync #(
   parameter int W = 1
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] d, // asynchronous input
   output logic [W-1:0] q // synchronised output
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stab;
   } cct_sync_t;
   cct_sync_t s;
   cct_sync_t next_s;
   always_comb
   begin
      next_s.meta = d;
      next_s.stab = s.meta;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end
   assign q = s.stab;
endmodule

// ===== hdl/cct_tick_div.sv
// clock divider giving one tick per divisor clocks; divisor taken in each tick cycle
`timescale 1ns/100ps
module cct_tick_div #(
   parameter int W = 11
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] div, // clocks per tick, zero treated as one
   output logic tick // one-cycle pulse in the last clock of each period
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic [W-1:0] div_q;
   } cct_div_t;
   cct_div_t s;
   cct_div_t next_s;
   always_comb
   begin
      next_s = s;
      if (s.cnt >= s.div_q - W'(1))
      begin
         // a new divisor only ever starts a fresh period
         next_s.cnt = '0;
         next_s.div_q = (div == '0) ? W'(1) : div;
      end
      else
         next_s.cnt = s.cnt + W'(1);
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.div_q <= W'(1);
      end
      else
         s <= next_s;
   end
   // tick shares its cycle with the reload, so a divisor chosen from the state
   // that the user enters on this tick times exactly that next period
   assign tick = (s.cnt >= s.div_q - W'(1));
endmodule

// ===== hdl/cct_core_timing.sv
// machine cycle sequencer, external data move strobes, data pointers and timers
`timescale 1ns/100ps
module cct_core_timing (
   input wire logic clk, // system clock, 100 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire logic irq_pending, // interrupt pending from core logic
   input wire logic program_memory_source_pin, // low selects external code
   input wire logic [7:0] ext_rdata, // external data bus in
   output logic [15:0] ext_addr, // external address
   output logic [7:0] ext_wdata, // external data bus out
   output logic ext_data_oe, // data bus output enable
   output logic wr_n, // write strobe, port 3 bit 6
   output logic rd_n, // read strobe, port 3 bit 7
   output logic ale, // address latch strobe
   output logic prog_fetch_n, // external program fetch strobe
   output logic mc_strobe, // one pulse per machine cycle
   output logic [2:0] tmr_tick // timer increment pulses
);
   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      cct_pkg::cct_ctrl_t ctrl;
      logic [1:0][15:0] data_pointer_pair;
      logic [2:0][15:0] tmr;
      cct_pkg::cct_state_t st;
      logic pend;
      cct_pkg::cct_instr_t ins;
      logic [1:0] bytes_left;
      logic [3:0] stretch_left;
      logic [15:0] cyc_cnt;
      logic [15:0] last_cycles;
      logic [7:0] last_rdata;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic [15:0] ext_addr;
      logic [7:0] ext_wdata;
      logic ext_data_oe;
      logic wr_n;
      logic rd_n;
      logic ale;
      logic prog_fetch_n;
      logic mc_strobe;
      logic [2:0] tmr_tick;
   } cct_core_t;
   cct_core_t s;
   cct_core_t next_s;
   logic code_pin;
   logic [7:0] rdata_sync;
   logic mc_tick;
   logic [10:0] mc_div;
   logic [2:0] pre_tick;
   logic code_ext;
   logic x_cycle;
   logic [3:0] wr_stretch;
   logic apb_wr;
   logic apb_rd;
   logic done;
   logic sel;
   logic [15:0] dp_next;
   cct_pkg::cct_ctrl_t wctrl;
   // ****************************************************************
   // pin synchronisers and dividers
   // ****************************************************************
   cct_sync #(.W(1)) u_code_sync (
      .clk(clk),
      .rst(rst),
      .d(program_memory_source_pin),
      .q(code_pin)
   );
   cct_sync #(.W(8)) u_rdata_sync (
      .clk(clk),
      .rst(rst),
      .d(ext_rdata),
      .q(rdata_sync)
   );
   cct_tick_div #(.W(cct_pkg::DIV_W)) u_mc_div (
      .clk(clk),
      .rst(rst),
      .div(mc_div),
      .tick(mc_tick)
   );
   genvar gi;
   generate
      for (gi = 0; gi < cct_pkg::NUM_TMR; gi++)
      begin : g_tmr
         cct_tick_div #(.W(cct_pkg::DIV_W)) u_pre (
            .clk(clk),
            .rst(rst),
            .div(s.ctrl.tmr_fast[gi] ? cct_pkg::DIV_NORMAL : cct_pkg::DIV_TMR_LEGACY),
            .tick(pre_tick[gi])
         );
      end
   endgenerate
   assign code_ext = ~code_pin;
   // ****************************************************************
   // machine cycle length
   // ****************************************************************
   // the divisor is sampled only at a tick, so a mode change never splits a cycle
   always_comb
   begin
      if (next_s.ctrl.pmm)
         mc_div = cct_pkg::DIV_PMM;
      else if (x_cycle)
         mc_div = 11'({next_s.ctrl.ext_mode} + 3'h1);
      else
         mc_div = cct_pkg::DIV_NORMAL;
   end
   // ****************************************************************
   // sequencer, bus slave and timers
   // ****************************************************************
   always_comb
   begin
      next_s = s;
      apb_wr = psel & penable & pwrite & s.pready;
      apb_rd = psel & penable & ~s.pready;
      done = 1'b0;
      sel = s.ctrl.dp_sel;
      dp_next = s.data_pointer_pair[sel];
      wctrl = cct_pkg::cct_ctrl_t'(pwdata);
      wr_stretch = (wctrl.stretch > cct_pkg::STRETCH_MAX) ? cct_pkg::STRETCH_MAX : wctrl.stretch;
      next_s.pready = psel & penable & ~s.pready;
      next_s.pslverr = 1'b0;
      next_s.prdata = '0;
      // register writes, taken at the completing edge
      if (apb_wr)
      begin
         unique case (paddr)
            cct_pkg::ADDR_CTRL:
            begin
               next_s.ctrl = wctrl;
               next_s.ctrl.rsv_hi = '0;
               next_s.ctrl.rsv_mid = 1'b0;
               next_s.ctrl.rsv_lo = 1'b0;
               next_s.ctrl.stretch = wr_stretch;
            end
            cct_pkg::ADDR_DPTR0: next_s.data_pointer_pair[0] = pwdata[15:0];
            cct_pkg::ADDR_DPTR1: next_s.data_pointer_pair[1] = pwdata[15:0];
            cct_pkg::ADDR_INSTR:
            begin
               // a request while busy is dropped; software polls busy first
               if (!s.pend && s.st == cct_pkg::ST_IDLE)
               begin
                  next_s.pend = 1'b1;
                  next_s.ins = cct_pkg::cct_instr_t'(pwdata);
               end
            end
            cct_pkg::ADDR_TMR0: next_s.tmr[0] = pwdata[15:0];
            cct_pkg::ADDR_TMR1: next_s.tmr[1] = pwdata[15:0];
            cct_pkg::ADDR_TMR2: next_s.tmr[2] = pwdata[15:0];
            default: ;
         endcase
      end
      // read data and error are registered at the same edge that raises pready
      if (apb_rd)
      begin
         unique case (paddr)
            cct_pkg::ADDR_CTRL: next_s.prdata = s.ctrl;
            cct_pkg::ADDR_DPTR0: next_s.prdata = {16'h0, s.data_pointer_pair[0]};
            cct_pkg::ADDR_DPTR1: next_s.prdata = {16'h0, s.data_pointer_pair[1]};
            cct_pkg::ADDR_INSTR: next_s.prdata = {s.last_cycles, s.last_rdata, 7'h0,
                                                  s.pend | (s.st != cct_pkg::ST_IDLE)};
            cct_pkg::ADDR_STATUS: next_s.prdata = {28'h0, s.ctrl.dp_sel,
                                                   s.pend | (s.st != cct_pkg::ST_IDLE),
                                                   code_ext, s.ctrl.pmm};
            cct_pkg::ADDR_TMR0: next_s.prdata = {16'h0, s.tmr[0]};
            cct_pkg::ADDR_TMR1: next_s.prdata = {16'h0, s.tmr[1]};
            cct_pkg::ADDR_TMR2: next_s.prdata = {16'h0, s.tmr[2]};
            default: next_s.pslverr = 1'b1;
         endcase
      end
      else if (psel & penable & ~s.pready & pwrite)
      begin
         next_s.pslverr = (paddr[1:0] != 2'h0) || (paddr > cct_pkg::ADDR_TMR2);
      end
      if (s.ctrl.swb_en && irq_pending)
         next_s.ctrl.pmm = 1'b0;
      // timers count on their own prescaler, not on the machine cycle
      for (int i = 0; i < cct_pkg::NUM_TMR; i++)
      begin
         next_s.tmr_tick[i] = pre_tick[i] & s.ctrl.tmr_run[i];
         if (pre_tick[i] && s.ctrl.tmr_run[i])
            next_s.tmr[i] = s.tmr[i] + 16'h1;
      end
      // the sequencer moves only at machine cycle boundaries
      if (mc_tick)
      begin
         if (s.st != cct_pkg::ST_IDLE)
            next_s.cyc_cnt = s.cyc_cnt + 16'h1;
         unique case (s.st)
            cct_pkg::ST_IDLE:
            begin
               if (s.pend)
               begin
                  next_s.pend = 1'b0;
                  next_s.cyc_cnt = '0;
                  next_s.st = cct_pkg::ST_FETCH;
                  // the reserved kind is fetched like a plain instruction
                  if (s.ins.kind == cct_pkg::KIND_XREAD || s.ins.kind == cct_pkg::KIND_XWRITE)
                     next_s.bytes_left = 2'h1;
                  else
                     next_s.bytes_left = (s.ins.nbytes == 2'h0) ? 2'h1 : s.ins.nbytes;
               end
            end
            cct_pkg::ST_FETCH:
            begin
               next_s.bytes_left = s.bytes_left - 2'h1;
               if (s.bytes_left == 2'h1)
               begin
                  if (s.ins.kind == cct_pkg::KIND_XREAD || s.ins.kind == cct_pkg::KIND_XWRITE)
                  begin
                     next_s.st = cct_pkg::ST_XACC;
                     next_s.stretch_left = s.ctrl.stretch;
                  end
                  else if (s.ins.nbytes == 2'h3)
                     done = 1'b1;
                  else
                     next_s.st = cct_pkg::ST_EXEC;
               end
            end
            cct_pkg::ST_EXEC: done = 1'b1;
            cct_pkg::ST_XACC:
            begin
               if (s.stretch_left == 4'h0)
               begin
                  done = 1'b1;
                  if (s.ins.kind == cct_pkg::KIND_XREAD)
                     next_s.last_rdata = rdata_sync;
                  // pointer side effects are those of the original move
                  if (s.ctrl.dp_auto)
                  begin
                     dp_next = s.ctrl.dp_dec ? s.data_pointer_pair[sel] - 16'h1 : s.data_pointer_pair[sel] + 16'h1;
                     next_s.data_pointer_pair[sel] = dp_next;
                  end
                  if (s.ctrl.dp_toggle)
                     next_s.ctrl.dp_sel = ~s.ctrl.dp_sel;
               end
               else
                  next_s.stretch_left = s.stretch_left - 4'h1;
            end
            default: next_s.st = cct_pkg::ST_IDLE;
         endcase
         if (done)
         begin
            next_s.st = cct_pkg::ST_IDLE;
            next_s.last_cycles = s.cyc_cnt + 16'h1;
         end
      end
      // ****************************************************************
      // pin outputs, registered from the next state
      // ****************************************************************
      x_cycle = (next_s.st == cct_pkg::ST_XACC) || (next_s.st == cct_pkg::ST_FETCH && code_ext);
      next_s.mc_strobe = mc_tick;
      next_s.ale = mc_tick & (~next_s.ctrl.ale_quiet | x_cycle);
      next_s.prog_fetch_n = ~(next_s.st == cct_pkg::ST_FETCH && code_ext);
      next_s.wr_n = ~(next_s.st == cct_pkg::ST_XACC &&
                      next_s.ins.kind == cct_pkg::KIND_XWRITE);
      next_s.rd_n = ~(next_s.st == cct_pkg::ST_XACC &&
                      next_s.ins.kind == cct_pkg::KIND_XREAD);
      next_s.ext_data_oe = ~next_s.wr_n;
      next_s.ext_wdata = next_s.wr_n ? 8'h0 : next_s.ins.wdata;
      next_s.ext_addr = (next_s.st == cct_pkg::ST_XACC) ? s.data_pointer_pair[s.ctrl.dp_sel] : 16'h0;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
         s.ctrl <= cct_pkg::CTRL_RESET;
         s.st <= cct_pkg::ST_IDLE;
         s.wr_n <= 1'b1;
         s.rd_n <= 1'b1;
         s.prog_fetch_n <= 1'b1;
      end
      else
         s <= next_s;
   end
   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign ext_addr = s.ext_addr;
   assign ext_wdata = s.ext_wdata;
   assign ext_data_oe = s.ext_data_oe;
   assign wr_n = s.wr_n;
   assign rd_n = s.rd_n;
   assign ale = s.ale;
   assign prog_fetch_n = s.prog_fetch_n;
   assign mc_strobe = s.mc_strobe;
   assign tmr_tick = s.tmr_tick;
endmodule

// ===== test/cct_core_timing_asserts.sv
// assertion checker bound to the core cycle timing control ports
`timescale 1ns/100ps
module cct_core_timing_asserts (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset
   input wire logic psel, // apb select
   input wire logic penable, // apb access
   input wire logic pwrite, // apb write
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic irq_pending, // interrupt pending
   input wire logic program_memory_source_pin, // code source pin
   input wire logic ext_data_oe, // data bus enable
   input wire logic wr_n, // write strobe
   input wire logic rd_n, // read strobe
   input wire logic ale, // address latch strobe
   input wire logic prog_fetch_n, // external fetch strobe
   input wire logic mc_strobe, // machine cycle pulse
   input wire logic [2:0] tmr_tick // timer pulses
);
   // ********
   // shadow of the control register and gap counters
   // ********
   cct_pkg::cct_ctrl_t sh;
   logic [10:0] gap, tgap, swc;
   logic [3:0] alen, st;
   logic lpmm, lpmm2, tok, mcq;
   wire ctl_wr = psel && penable && pready && pwrite && !pslverr && paddr == cct_pkg::ADDR_CTRL;
   assign st = (sh.stretch > cct_pkg::STRETCH_MAX) ? cct_pkg::STRETCH_MAX : sh.stretch;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sh <= cct_pkg::CTRL_RESET;
         gap <= 11'h000;
         tgap <= 11'h000;
         alen <= 4'h0;
         lpmm <= 1'b0;
         lpmm2 <= 1'b0;
         tok <= 1'b0;
         swc <= 11'h000;
         mcq <= 1'b0;
      end
      else
      begin
         if (ctl_wr)
            sh <= cct_pkg::cct_ctrl_t'(pwdata);
         // the hardware clear beats a software write in the same cycle
         if (irq_pending && sh.swb_en)
            sh.pmm <= 1'b0;
         gap <= mc_strobe ? 11'h000 : gap + 11'h001;
         tgap <= tmr_tick[0] ? 11'h000 : tgap + 11'h001;
         alen <= (rd_n && wr_n) ? 4'h0 : alen + 4'h1;
         if (mc_strobe)
         begin
            lpmm <= sh.pmm && sh.ext_mode == 2'h0;
            lpmm2 <= lpmm;
         end
         tok <= (tmr_tick[0] || tok) && sh.tmr_run[0] && !sh.tmr_fast[0];
         // clocks from a switchback request until two machine cycles in a row
         mcq <= mc_strobe;
         if (swc != 11'h000)
            swc <= (mc_strobe && mcq) ? 11'h000 : swc + 11'h001;
         else if (irq_pending && sh.swb_en && sh.pmm)
            swc <= 11'h001;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_norm_cycle: assert property (mc_strobe && !sh.pmm && sh.ext_mode == 2'h0 ##1 !sh.pmm |-> mc_strobe)
      else $error("machine cycle longer than one clock");
   a_pmm_period: assert property (mc_strobe && lpmm && lpmm2 && sh.pmm |-> gap == 11'h3ff)
      else $error("slow machine cycle not 1024 clocks");
   a_swb_exit: assert property (swc < 11'h44c)
      else $error("switchback did not restore full speed");
   a_tmr_legacy: assert property (tmr_tick[0] && tok |-> tgap == 11'h00b)
      else $error("legacy timer tick not every 12 clocks");
   a_tmr_fast: assert property (sh.tmr_fast[1] ##1 tmr_tick[1] && sh.tmr_run[1] && sh.tmr_fast[1] ##1
      sh.tmr_run[1] && sh.tmr_fast[1] |-> tmr_tick[1])
      else $error("fast timer missed a clock");
   a_rd_len: assert property ($rose(rd_n) && !sh.pmm && sh.ext_mode == 2'h0 |-> alen == st + 4'h1)
      else $error("read strobe length wrong for stretch");
   a_wr_len: assert property ($rose(wr_n) && !sh.pmm && sh.ext_mode == 2'h0 |-> alen == st + 4'h1)
      else $error("write strobe length wrong for stretch");
   a_wr_drive: assert property (!wr_n |-> rd_n && ext_data_oe)
      else $error("write strobe without driven data");
   a_rd_drive: assert property (!rd_n |-> wr_n && !ext_data_oe)
      else $error("read strobe while driving bus");
   a_ale_quiet: assert property ((sh.ale_quiet && rd_n && wr_n && prog_fetch_n) [*3] |-> !$past(ale))
      else $error("latch strobe outside external access");
   a_int_code: assert property (program_memory_source_pin [*5] |-> prog_fetch_n)
      else $error("external fetch with pin high");
   c_pmm: cover property (mc_strobe && lpmm2);
   c_rd: cover property ($rose(rd_n));
   c_wr: cover property ($rose(wr_n));
endmodule
bind cct_core_timing cct_core_timing_asserts u_chk (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .irq_pending(irq_pending),
   .program_memory_source_pin(program_memory_source_pin), .ext_data_oe(ext_data_oe),
   .wr_n(wr_n), .rd_n(rd_n), .ale(ale), .prog_fetch_n(prog_fetch_n),
   .mc_strobe(mc_strobe), .tmr_tick(tmr_tick));

// ===== test/cct_xmem_model.sv
// behavioural external data memory answering the read and write strobes
`timescale 1ns/100ps
module cct_xmem_model (
   input wire logic clk, // system clock
   input wire logic rd_n, // read strobe
   input wire logic wr_n, // write strobe
   input wire logic [15:0] ext_addr, // address
   input wire logic [7:0] ext_wdata, // write data
   input wire logic [1:0] lat, // clocks before read data is valid
   output logic [7:0] ext_rdata // read data to device
);
   logic [7:0] mem [16];
   logic [1:0] cnt;
   initial
   begin
      ext_rdata = 8'h5a;
      cnt = 2'h0;
   end
   always @(posedge clk)
   begin
      if (!wr_n)
         mem[ext_addr[3:0]] <= ext_wdata;
      cnt <= rd_n ? 2'h0 : ((cnt == 2'h3) ? cnt : cnt + 2'h1);
      if (!rd_n && cnt >= lat)
         ext_rdata <= mem[ext_addr[3:0]];
      else
         ext_rdata <= ~ext_rdata; // a slow or idle bus never holds stale data
   end
endmodule

// ===== test/core_cycle_timing_control_tb_top.sv
// self-checking testbench of the core cycle timing control block
`timescale 1ns/100ps
module core_cycle_timing_control_tb_top;
   localparam logic [15:0] PCYC [4] = '{16'h2, 16'h2, 16'h3, 16'h3};
   logic clk, rst, psel, penable, pwrite, irq_pending, pin, pready, pslverr;
   logic ext_data_oe, wr_n, rd_n, ale, prog_fetch_n, mc_strobe;
   logic [7:0] paddr, ext_rdata, ext_wdata;
   logic [31:0] pwdata, prdata, rv, d0, d1;
   logic [15:0] ext_addr;
   logic [2:0] tmr_tick;
   logic [1:0] lat;
   logic [33:0] expq [$];
   logic [33:0] mon_e;
   int error_cnt, checks, pfcnt;
   cct_core_timing u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq_pending(irq_pending), .program_memory_source_pin(pin),
      .ext_rdata(ext_rdata), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
      .ext_data_oe(ext_data_oe), .wr_n(wr_n), .rd_n(rd_n), .ale(ale),
      .prog_fetch_n(prog_fetch_n), .mc_strobe(mc_strobe), .tmr_tick(tmr_tick));
   cct_xmem_model u_mem (.clk(clk), .rd_n(rd_n), .wr_n(wr_n), .ext_addr(ext_addr),
      .ext_wdata(ext_wdata), .lat(lat), .ext_rdata(ext_rdata));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ********
   // bus tasks and comparison
   // ********
   task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [33:0] e);
      int n;
      if (!w)
         expq.push_back(e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n == 20)
         error_cnt++;
      rv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0, {1'b1, e});
   endtask
   task automatic poll(input int b);
      int n;
      n = 0;
      rv = 32'hffffffff;
      while (rv[b] !== 1'b0 && n < 400)
      begin
         apb(1'b0, cct_pkg::ADDR_STATUS, 32'h0, 34'h0);
         n++;
      end
      if (n == 400)
         error_cnt++;
   endtask
   task automatic run_ins(input logic [31:0] ins, input logic [15:0] cyc, input logic [7:0] lrd);
      wr(cct_pkg::ADDR_INSTR, ins);
      poll(2);
      rdx(cct_pkg::ADDR_INSTR, {1'b0, cyc, lrd, 8'h00});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(posedge clk)
      if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      begin
         mon_e = expq.pop_front();
         if (mon_e[33])
            chk("apb read", {pslverr, prdata}, mon_e[32:0]);
      end
   always @(posedge clk)
      if (prog_fetch_n === 1'b0 || rd_n === 1'b0)
         pfcnt++;
   initial
   begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      tally_and_finish;
   end
   initial
   begin
      {rst, pin} = 2'h3;
      {psel, penable, pwrite, irq_pending} = 4'h0;
      {paddr, pwdata, lat} = '0;
      {error_cnt, checks, pfcnt} = '0;
      d0 = $urandom(8);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdx(cct_pkg::ADDR_CTRL, {1'b0, cct_pkg::CTRL_RESET});
      rdx(cct_pkg::ADDR_STATUS, 33'h0);
      rdx(8'h20, {1'b1, 32'h0});
      rdx(8'h06, {1'b1, 32'h0});
      wr(cct_pkg::ADDR_STATUS, 32'hf);
      rdx(cct_pkg::ADDR_STATUS, 33'h0);
      for (int i = 0; i < 4; i++)
         run_ins({28'h0, (i == 3) ? 2'h3 : 2'h0, 2'(i)}, PCYC[i], 8'h00);
      d0 = $urandom;
      d1 = $urandom;
      wr(cct_pkg::ADDR_DPTR0, 32'h2);
      wr(cct_pkg::ADDR_DPTR1, 32'h9);
      wr(cct_pkg::ADDR_CTRL, 32'h5000);
      run_ins({16'h0, d0[7:0], 8'h09}, 16'h2, 8'h00);
      rdx(cct_pkg::ADDR_DPTR0, 33'h3);
      rdx(cct_pkg::ADDR_STATUS, 33'h8);
      run_ins({16'h0, d1[7:0], 8'h09}, 16'h2, 8'h00);
      rdx(cct_pkg::ADDR_DPTR1, 33'ha);
      rdx(cct_pkg::ADDR_STATUS, 33'h0);
      wr(cct_pkg::ADDR_DPTR0, 32'h2);
      wr(cct_pkg::ADDR_CTRL, 32'h3040);
      run_ins(32'h5, 16'h6, d0[7:0]);
      rdx(cct_pkg::ADDR_DPTR0, 33'h1);
      lat <= 2'h2;
      wr(cct_pkg::ADDR_DPTR1, 32'h9);
      wr(cct_pkg::ADDR_CTRL, 32'h8080);
      run_ins(32'h5, 16'ha, d1[7:0]);
      wr(cct_pkg::ADDR_CTRL, 32'hf4);
      rdx(cct_pkg::ADDR_CTRL, 33'ha4);
      run_ins({16'h0, d0[15:8], 8'h09}, 16'hc, d1[7:0]);
      run_ins(32'h2, 16'h3, d1[7:0]);
      wr(cct_pkg::ADDR_DPTR1, d0);
      rdx(cct_pkg::ADDR_DPTR1, {17'h0, d0[15:0]});
      wr(cct_pkg::ADDR_TMR2, 32'h1234);
      rdx(cct_pkg::ADDR_TMR2, 33'h1234);
      wr(cct_pkg::ADDR_CTRL, 32'hc0200);
      repeat (60) @(posedge clk);
      pin <= 1'b0;
      repeat (4) @(posedge clk);
      rdx(cct_pkg::ADDR_STATUS, 33'h2);
      pfcnt = 0;
      run_ins(32'h2, 16'h3, d1[7:0]);
      chk("external fetch clocks", 33'(pfcnt), 33'h2);
      pin <= 1'b1;
      lat <= 2'h0;
      // two clocks per external cycle, stretch one: four strobe clocks
      wr(cct_pkg::ADDR_CTRL, 32'h10010);
      pfcnt = 0;
      run_ins(32'h5, 16'h3, d0[15:8]);
      chk("stretched read clocks", 33'(pfcnt), 33'h4);
      wr(cct_pkg::ADDR_CTRL, 32'h3);
      repeat (4200) @(posedge clk);
      rdx(cct_pkg::ADDR_STATUS, 33'h1);
      irq_pending <= 1'b1;
      poll(0);
      irq_pending <= 1'b0;
      rdx(cct_pkg::ADDR_CTRL, 33'h2);
      repeat (4) @(posedge clk);
      tally_and_finish;
   end
endmodule
